// ---- shared/lnkled_pkg.sv ----
/*
 * Package for the link indicator control block: register offsets, field
 * positions, reset values, blink timing and the carrier structs.
 * Assumes a 20 MHz core clock and a 5-bit management register address.
 */
package lnkled_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [4:0]  CTRL_ADDR      = 5'h18;   // Indicator control register
    localparam logic [4:0]  PHYCR_ADDR     = 5'h19;   // Holds the stretch skip bit
    localparam logic [15:0] CTRL_RESET     = 16'h0400; // Control reset value
    localparam logic [15:0] PHYCR_RESET    = 16'h0000; // Stretch skip resets clear

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RATE_LSB      = 9;   // Blink rate field low bit
    localparam int RATE_MSB      = 10;  // Blink rate field high bit
    localparam int LEVEL_BIT     = 7;   // Active level bit
    localparam int OVERRIDE_BIT  = 4;   // Manual override bit
    localparam int FORCED_BIT    = 1;   // Forced value bit
    localparam int SKIP_BIT      = 7;   // Stretch skip bit in PHYCR

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ        = 20_000_000;  // Core clock rate
    localparam int RATE0_MS      = 50;          // Code 0 on/off time
    localparam int RATE1_MS      = 100;         // Code 1 on/off time
    localparam int RATE2_MS      = 200;         // Code 2 on/off time
    localparam int RATE3_MS      = 500;         // Code 3 on/off time
    localparam int STRETCH_MS    = 50;          // Activity stretch time
    localparam int CYC_PER_MS    = CLK_HZ / 1000;
    localparam int RATE0_CYC     = RATE0_MS * CYC_PER_MS;
    localparam int RATE1_CYC     = RATE1_MS * CYC_PER_MS;
    localparam int RATE2_CYC     = RATE2_MS * CYC_PER_MS;
    localparam int RATE3_CYC     = RATE3_MS * CYC_PER_MS;
    localparam int STRETCH_CYC   = STRETCH_MS * CYC_PER_MS;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    // Management write/read request
    typedef struct packed {
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
        logic [4:0]  addr;   // Register address
        logic [15:0] wdata;  // Write data
    } lnkled_req_s;

    // Live link state
    typedef struct packed {
        logic link_up;   // Link established
        logic activity;  // Activity pulse
    } lnkled_stat_s;

endpackage : lnkled_pkg

// ---- core/lnkled_ctrl.sv ----
/*
 * Link indicator control: control register, strap-seeded polarity,
 * blink and stretch timers, manual override of the indicator pin.
 * Read data comes back one cycle after the read strobe.
 * Assumes management accesses arrive as single-cycle strobes on i_mclk.
 * Assumes the strap pin is settled while reset is held.
 * Assumes link and activity inputs are already synchronous.
 */
`timescale 1ns/10ps

module lnkled_ctrl #(
    parameter int RATE0_CYCLES   = lnkled_pkg::RATE0_CYC,   // 50 ms
    parameter int RATE1_CYCLES   = lnkled_pkg::RATE1_CYC,   // 100 ms
    parameter int RATE2_CYCLES   = lnkled_pkg::RATE2_CYC,   // 200 ms
    parameter int RATE3_CYCLES   = lnkled_pkg::RATE3_CYC,   // 500 ms
    parameter int STRETCH_CYCLES = lnkled_pkg::STRETCH_CYC  // Activity hold
) (
    input  wire logic                   i_mclk,
    input  wire logic                   i_resetn,
    input  wire logic                   i_strap_level,
    input  wire lnkled_pkg::lnkled_req_s i_req,
    input  wire lnkled_pkg::lnkled_stat_s i_stat,
    output logic [15:0]                 o_rdata,
    output logic                        o_rvalid,
    output logic                        o_indicator_out_0
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    // Timer wide enough for the longest default count
    localparam int CW = 24;                         // Timer width

    // Strap capture sequencing
    typedef enum logic [1:0] {
        LNKLED_SEED,     // Waiting to capture strap
        LNKLED_RUN       // Normal running
    } lnkled_state_e;

    // Registers
    lnkled_state_e state_reg;                       // Strap capture state
    logic [1:0]    rate_reg;                        // Blink rate code
    logic          level_reg;                       // Active level
    logic          override_reg;                    // Manual override
    logic          forced_reg;                      // Forced value
    logic          skip_reg;                        // Stretch skip
    logic [CW-1:0] blink_cnt_reg;                   // Blink half-period timer
    logic          blink_ph_reg;                    // Blink phase
    logic [CW-1:0] hold_cnt_reg;                    // Activity stretch timer
    logic [15:0]   rdata_reg;                       // Read data
    logic          rvalid_reg;                      // Read valid
    logic          out_reg;                         // Indicator pin

    // Combinational nets
    wire           wr_ctrl;                         // Write to control reg
    wire           wr_phycr;                        // Write to PHYCR
    wire [CW-1:0]  half_period;                     // Selected half period
    wire           blink_wrap;                      // Half period expired
    wire           act_stretched;                   // Stretched activity
    wire           act_eff;                         // Activity after skip
    wire           lit;                             // Logical on state
    wire           pin_next;                        // Indicator next value
    wire [15:0]    ctrl_view;                       // Control readback
    wire [15:0]    phycr_view;                      // PHYCR readback
    wire [15:0]    rd_mux;                          // Read selection

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // control and PHYCR offset decode
    assign wr_ctrl  = i_req.wr && (i_req.addr == lnkled_pkg::CTRL_ADDR);
    assign wr_phycr = i_req.wr && (i_req.addr == lnkled_pkg::PHYCR_ADDR);

    assign ctrl_view = ({14'h0000, rate_reg} << lnkled_pkg::RATE_LSB)
                     | ({15'h0000, level_reg} << lnkled_pkg::LEVEL_BIT)
                     | ({15'h0000, override_reg} << lnkled_pkg::OVERRIDE_BIT)
                     | ({15'h0000, forced_reg} << lnkled_pkg::FORCED_BIT);
    assign phycr_view = {15'h0000, skip_reg} << lnkled_pkg::SKIP_BIT;
    // Read mux, unmapped addresses return zero
    assign rd_mux = (i_req.addr == lnkled_pkg::CTRL_ADDR)  ? ctrl_view  :
                    (i_req.addr == lnkled_pkg::PHYCR_ADDR) ? phycr_view : 16'h0000;

    assign half_period = (rate_reg == 2'h0) ? CW'(RATE0_CYCLES - 1) :
                         (rate_reg == 2'h1) ? CW'(RATE1_CYCLES - 1) :
                         (rate_reg == 2'h2) ? CW'(RATE2_CYCLES - 1) :
                                              CW'(RATE3_CYCLES - 1);
    // Wrap on >= so a shorter new rate restarts at once
    assign blink_wrap = (blink_cnt_reg >= half_period);

    assign act_stretched = i_stat.activity || (hold_cnt_reg != '0);
    assign act_eff       = skip_reg ? i_stat.activity : act_stretched;

    // steady on link, blink on activity
    // Phase set means dark while active
    assign lit = i_stat.link_up && !(act_eff && blink_ph_reg);

    assign pin_next = override_reg ? forced_reg : (level_reg ? lit : !lit);

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Field storage and strap seeding
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg    <= LNKLED_SEED;
            rate_reg     <= lnkled_pkg::CTRL_RESET[lnkled_pkg::RATE_MSB:lnkled_pkg::RATE_LSB];
            level_reg    <= lnkled_pkg::CTRL_RESET[lnkled_pkg::LEVEL_BIT];
            override_reg <= lnkled_pkg::CTRL_RESET[lnkled_pkg::OVERRIDE_BIT];
            forced_reg   <= lnkled_pkg::CTRL_RESET[lnkled_pkg::FORCED_BIT];
            skip_reg     <= lnkled_pkg::PHYCR_RESET[lnkled_pkg::SKIP_BIT];
        end else begin
            case (state_reg)
                LNKLED_SEED: begin
                    level_reg <= i_strap_level;
                    state_reg <= LNKLED_RUN;
                end
                // Stay here until the next reset
                LNKLED_RUN: begin
                    state_reg <= LNKLED_RUN;
                end
                default: begin
                    state_reg <= LNKLED_RUN;
                end
            endcase
            if (wr_ctrl) begin
                rate_reg     <= i_req.wdata[lnkled_pkg::RATE_MSB:lnkled_pkg::RATE_LSB];
                level_reg    <= i_req.wdata[lnkled_pkg::LEVEL_BIT];
                override_reg <= i_req.wdata[lnkled_pkg::OVERRIDE_BIT];
                forced_reg   <= i_req.wdata[lnkled_pkg::FORCED_BIT];
            end
            // Stretch skip lives in the neighbouring register
            if (wr_phycr) begin
                skip_reg <= i_req.wdata[lnkled_pkg::SKIP_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Registered read data, one cycle after strobe
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_reg  <= 16'h0000;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= i_req.rd;
            // Data loads only on a read, so it holds
            if (i_req.rd) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    // blink half-period timer
    // Free-running, so a rate change applies to the half period in progress
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            blink_cnt_reg <= '0;
            blink_ph_reg  <= 1'b0;
        end else if (blink_wrap) begin
            blink_cnt_reg <= '0;
            blink_ph_reg  <= !blink_ph_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + CW'(1);
        end
    end

    // Activity stretch: reload on activity, count down
    // Zero count means no recent activity
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            hold_cnt_reg <= '0;
        end else if (i_stat.activity) begin
            hold_cnt_reg <= CW'(STRETCH_CYCLES);
        end else if (hold_cnt_reg != '0) begin
            hold_cnt_reg <= hold_cnt_reg - CW'(1);
        end
    end

    // ------------------------------------------------------------------
    // Indicator pin
    // ------------------------------------------------------------------
    // registered pin drive
    // Resets dark for the default active-low setting
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            out_reg <= 1'b1;
        end else begin
            out_reg <= pin_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output straight from a flop
    assign o_rdata           = rdata_reg;
    assign o_rvalid          = rvalid_reg;
    assign o_indicator_out_0 = out_reg;

endmodule : lnkled_ctrl

// ---- tb/lnkled_checker.sv ----
/* Port checker for lnkled_ctrl.
   Assumes it is bound to lnkled_ctrl. */
`timescale 1ns/10ps
module lnkled_checker (
    input wire logic                      i_mclk,
    input wire logic                      i_resetn,
    input wire logic                      i_strap_level,
    input wire lnkled_pkg::lnkled_req_s   i_req,
    input wire lnkled_pkg::lnkled_stat_s  i_stat,
    input wire logic [15:0]               o_rdata,
    input wire logic                      o_rvalid,
    input wire logic                      o_indicator_out_0
);
    logic first_q, lvl_q, ovr_q, skip_q;  // Mirror of level, override, skip
    wire  wr18 = i_req.wr && i_req.addr == lnkled_pkg::CTRL_ADDR;
    wire  wr19 = i_req.wr && i_req.addr == lnkled_pkg::PHYCR_ADDR;
    wire  rd18 = i_req.rd && i_req.addr == lnkled_pkg::CTRL_ADDR;
    wire  rdun = i_req.rd && !rd18 && i_req.addr != lnkled_pkg::PHYCR_ADDR;
    // Track the fields that steer the pin
    always_ff @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            {first_q, lvl_q, ovr_q, skip_q} <= 4'h8;
        end else begin
            first_q <= 1'b0;
            if (wr18) {lvl_q, ovr_q} <= {i_req.wdata[7], i_req.wdata[4]};
            else if (first_q) lvl_q <= i_strap_level;
            if (wr19) skip_q <= i_req.wdata[7];
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    read_answer_a: assert property (i_req.rd |=> o_rvalid)
        else $error("read not answered");
    rvalid_cause_a: assert property (!i_req.rd |=> !o_rvalid)
        else $error("stray read valid");
    rdata_hold_a: assert property (!o_rvalid |-> $stable(o_rdata))
        else $error("read data moved");
    reserved_zero_a: assert property (o_rvalid |-> (o_rdata & 16'hF96D) == 16'h0000)
        else $error("reserved bit set");
    unmapped_zero_a: assert property (rdun |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    readback_a: assert property (wr18 && !i_req.rd ##1 rd18 && !i_req.wr
        |=> o_rdata == ($past(i_req.wdata, 2) & 16'h0692)) else $error("readback wrong");
    override_a: assert property (wr18 && i_req.wdata[4] ##1 !i_req.wr
        |=> o_indicator_out_0 == $past(i_req.wdata[1], 2)) else $error("override wrong");
    link_down_a: assert property (!first_q && !ovr_q && !i_stat.link_up
        |=> o_indicator_out_0 == !$past(lvl_q)) else $error("idle level wrong");
    steady_lit_a: assert property (!first_q && !ovr_q && skip_q && i_stat.link_up
        && !i_stat.activity |=> o_indicator_out_0 == $past(lvl_q)) else $error("lit wrong");
    cover property (wr18 && i_req.wdata[4]);
    cover property (skip_q && i_stat.activity && i_stat.link_up);
    cover property (o_rvalid && o_rdata[7]);
endmodule : lnkled_checker
bind lnkled_ctrl lnkled_checker u_chk (.i_mclk, .i_resetn, .i_strap_level, .i_req,
    .i_stat, .o_rdata, .o_rvalid, .o_indicator_out_0);

// ---- tb/tb_top.sv ----
/* Self-checking bench for lnkled_ctrl with short blink counts.
   Assumes the checker is bound from its own file. */
`timescale 1ns/10ps
module tb_top;
    logic                     i_mclk, i_resetn, i_strap_level;
    lnkled_pkg::lnkled_req_s  i_req;
    lnkled_pkg::lnkled_stat_s i_stat;
    logic [15:0]              o_rdata;
    logic                     o_rvalid, o_indicator_out_0;
    int                       fail_count = 0, n_checks = 0, n_cyc = 0;
    localparam int RC [4] = '{4, 8, 16, 40};  // Shortened on/off counts
    localparam logic [4:0] CA = lnkled_pkg::CTRL_ADDR;
    lnkled_ctrl #(.RATE0_CYCLES(RC[0]), .RATE1_CYCLES(RC[1]), .RATE2_CYCLES(RC[2]),
        .RATE3_CYCLES(RC[3]), .STRETCH_CYCLES(8)) DUT (.i_mclk, .i_resetn,
        .i_strap_level, .i_req, .i_stat, .o_rdata, .o_rvalid, .o_indicator_out_0);
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    // Cut a hang short
    always @(posedge i_mclk) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t %s: got %h want %h", $time, m, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge i_mclk);
        i_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_mclk);
        i_req.wr = 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [4:0] a, input logic [15:0] exp, input string m);
        @(negedge i_mclk);
        i_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge i_mclk);
        i_req.rd = 1'b0;
        check(o_rvalid, 16'h0001, m);
        check(o_rdata, exp, m);
    endtask : reg_rd
    task automatic wr_rd(input logic [4:0] a, input logic [15:0] d, input logic [15:0] exp,
                         input string m);
        @(negedge i_mclk);
        i_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_mclk);
        i_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge i_mclk);
        i_req.rd = 1'b0;
        check(o_rvalid, 16'h0001, m);
        check(o_rdata, exp, m);
    endtask : wr_rd
    task automatic pin_is(input logic e, input string m);
        repeat (2) @(negedge i_mclk);
        check(o_indicator_out_0, e, m);
    endtask : pin_is
    task automatic do_reset(input logic s);
        @(negedge i_mclk);
        i_resetn = 1'b0;
        i_strap_level = s;
        repeat (10) @(negedge i_mclk);
        check(o_indicator_out_0, 16'h0001, "pin in reset");
        i_resetn = 1'b1;
        @(negedge i_mclk);
    endtask : do_reset
    task automatic gap(output int n);
        logic p;
        p = o_indicator_out_0;
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while (o_indicator_out_0 === p && n < 200);
    endtask : gap
    task automatic t_regs;
        do_reset(1'b0);
        reg_rd(CA, 16'h0400, "ctrl reset");
        reg_rd(lnkled_pkg::PHYCR_ADDR, 16'h0000, "skip reset");
        reg_wr(5'h05, 16'hFFFF);
        reg_rd(5'h05, 16'h0000, "unmapped");
        wr_rd(CA, 16'hFFFF, 16'h0692, "reserved bits");
        pin_is(1'b1, "forced one");
        reg_wr(CA, 16'h0010);
        pin_is(1'b0, "forced zero");
        $display("test regs done");
    endtask : t_regs
    task automatic t_strap;
        do_reset(1'b1);
        reg_rd(CA, 16'h0480, "strap level");
        pin_is(1'b0, "idle high level");
        reg_wr(CA, 16'h0400);
        reg_rd(CA, 16'h0400, "level rewritten");
        pin_is(1'b1, "idle low level");
        i_stat.link_up = 1'b1;
        pin_is(1'b0, "lit low level");
        $display("test strap done");
    endtask : t_strap
    task automatic t_blink;
        int c;
        reg_wr(lnkled_pkg::PHYCR_ADDR, 16'h0080);
        reg_rd(lnkled_pkg::PHYCR_ADDR, 16'h0080, "skip set");
        i_stat = '{link_up: 1'b1, activity: 1'b1};
        for (int r = 0; r < 4; r++) begin
            reg_wr(CA, {5'h00, 2'(r), 9'h080});
            // Level flip and partial count settle first, third gap is whole
            gap(c);
            gap(c);
            gap(c);
            check(16'(c), 16'(RC[r]), "blink gap");
        end
        i_stat.activity = 1'b0;
        pin_is(1'b1, "steady lit");
        $display("test blink done");
    endtask : t_blink
    task automatic t_stretch;
        int z;
        reg_wr(lnkled_pkg::PHYCR_ADDR, 16'h0000);
        reg_rd(lnkled_pkg::PHYCR_ADDR, 16'h0000, "skip cleared");
        reg_wr(CA, 16'h0080);
        i_stat.activity = 1'b1;
        repeat (8) @(negedge i_mclk);
        i_stat.activity = 1'b0;
        z = 0;
        repeat (8) begin
            @(negedge i_mclk);
            if (o_indicator_out_0 === 1'b0) z++;
        end
        check(16'(z != 0), 16'h0001, "stretch blinks");
        repeat (4) @(negedge i_mclk);
        check(o_indicator_out_0, 16'h0001, "stretch over");
        $display("test stretch done");
    endtask : t_stretch
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        i_resetn = 1'b0;
        i_strap_level = 1'b0;
        i_req = '0;
        i_stat = '0;
        t_regs();
        t_strap();
        t_blink();
        t_stretch();
        tally_and_finish();
    end
endmodule : tb_top
